// [dpm_pkg.sv]
// shared constants, types and helpers for both ends of the converter control link
`default_nettype none
package dpm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // sample word and timing
  localparam int SAMPLE_W      = 10;
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCLK_HALF_NS  = 200;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] HALF_LAST = 4'(SCLK_HALF_CYC - 1);
  localparam logic [9:0] CODE_RESET = 10'h000;
  localparam logic [9:0] COMP_RESET = 10'h3FF;

  ////////////////////////////////////////////////////////////////////////////
  // serial frame: 8 instruction bits then 8 data bits, msb first
  localparam logic [2:0] BIT_LAST    = 3'h7;
  localparam logic [3:0] FRAME_LAST  = 4'hF;
  localparam logic [3:0] DATA_FIRST  = 4'h8;
  localparam int         INSTR_RD_BIT = 7;
  localparam int         ADDR_W       = 5;

  // device serial registers
  localparam logic [4:0] REG_CONFIG    = 5'h00;
  localparam logic [4:0] REG_STATUS    = 5'h01;
  localparam int         CFG_SLEEP_BIT = 0;
  localparam int         CFG_TWOS_BIT  = 1;
  localparam int         CFG_DIFF_BIT  = 2;
  localparam logic [7:0] CFG_RESET     = 8'h00;
  localparam int         STS_SPI_BIT   = 0;
  localparam int         STS_PD_BIT    = 1;

  ////////////////////////////////////////////////////////////////////////////
  // host apb registers
  localparam logic [11:0] APB_CTRL     = 12'h000;
  localparam logic [11:0] APB_SAMPLE   = 12'h004;
  localparam logic [11:0] APB_SPI_CMD  = 12'h008;
  localparam logic [11:0] APB_SPI_STAT = 12'h00C;
  localparam int          CTL_PIN_BIT   = 0;
  localparam int          CTL_SLEEP_BIT = 1;
  localparam int          CTL_TWOS_BIT  = 2;
  localparam int          CTL_DIFF_BIT  = 3;
  localparam logic [3:0]  CTRL_RESET    = 4'h1;
  localparam int          CMD_RD_BIT    = 15;
  localparam int          STAT_BUSY_BIT = 8;

  typedef enum logic [1:0] {
    D_IDLE  = 2'b00,
    D_INSTR = 2'b01,
    D_DATA  = 2'b10,
    D_DONE  = 2'b11
  } dpm_dev_state_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_LOW  = 2'b01,
    H_HIGH = 2'b10,
    H_END  = 2'b11
  } dpm_host_state_t;

  // twos complement maps onto the binary scale by flipping the msb
  function automatic logic [SAMPLE_W-1:0] dpm_core_code(input logic [SAMPLE_W-1:0] word,
                                                        input logic                twos);
    dpm_core_code = {word[SAMPLE_W-1] ^ twos, word[SAMPLE_W-2:0]};
  endfunction

endpackage
`default_nettype wire

// [dpm_if.sv]
// pins between the data/serial host and the converter control logic
`timescale 1ns/10ps
`default_nettype none
interface dpm_if;
  logic [9:0] sample;
  logic       mode_sel;
  logic       pd_cs;
  logic       clk_strap_sclk;
  logic       sdio_host_o;
  logic       sdio_host_oe;
  logic       sdio_dev_o;
  logic       sdio_dev_oe;
  logic       sdio;

  // resolved data line, weak pull-up when nobody drives
  assign sdio = sdio_dev_oe ? sdio_dev_o : (sdio_host_oe ? sdio_host_o : 1'b1);

  modport dev (
    input  sample,
    input  mode_sel,
    input  pd_cs,
    input  clk_strap_sclk,
    input  sdio,
    output sdio_dev_o,
    output sdio_dev_oe
  );

  modport host (
    output sample,
    output mode_sel,
    output pd_cs,
    output clk_strap_sclk,
    output sdio_host_o,
    output sdio_host_oe,
    input  sdio
  );
endinterface
`default_nettype wire

// [dpm_dev_end.sv]
// converter control end: sample capture, strap decode and serial configuration slave
//
// Overview of operation
// R1: ten-bit sample word, top line is msb
// R2: mode input high pins, low serial
// R3: mode input high resets serial registers
// R4: pin mode: sleep input high powers down
// R5: serial mode: chip select active low frames
// R6: pin mode format strap: low binary, high twos
// R7: pin mode clock strap: low single, high differential
// R8: serial mode: clock strap is serial clock
// R9: serial mode: format strap is bidirectional data
// R10: all ones full primary, zeros full complement
// R11: twos complement inverts msb before conversion
// R12: capture sample on rising edge, feed core
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module dpm_dev_end (
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  dpm_if.dev              pins,
  output logic [9:0]      o_core_code,
  output logic [9:0]      o_primary_level,
  output logic [9:0]      o_complement_level,
  output logic            o_powerdown,
  output logic            o_twos_comp,
  output logic            o_diff_clock,
  output logic            o_spi_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // mode and framing
  logic                   spi_mode;
  logic                   cs_active;
  logic                   sclk_q;
  logic                   sclk_rise;
  logic                   sclk_fall;

  assign spi_mode  = ~pins.mode_sel;              // see R2
  assign cs_active = spi_mode & ~pins.pd_cs;      // see R5

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= pins.clk_strap_sclk;
    end
  end

  // pins are synchronous, so one flop is enough for edge detection
  assign sclk_rise = cs_active & pins.clk_strap_sclk & ~sclk_q;   // see R8
  assign sclk_fall = cs_active & ~pins.clk_strap_sclk & sclk_q;   // see R8

  ////////////////////////////////////////////////////////////////////////////
  // serial engine
  dpm_pkg::dpm_dev_state_t state;
  logic [2:0]             bit_cnt;
  logic [7:0]             shreg;
  logic [7:0]             instr;
  logic                   rd_drive;
  logic [7:0]             cfg;
  logic                   is_read;
  logic [7:0]             shift_in;
  logic                   wr_pulse;
  logic [7:0]             rd_value;
  logic                   eff_twos;
  logic                   eff_diff;
  logic                   eff_pd;
  logic                   in_data;

  assign is_read  = instr[dpm_pkg::INSTR_RD_BIT];
  assign in_data  = (state == dpm_pkg::D_DATA);
  assign shift_in = {shreg[6:0], pins.sdio};      // see R9

  always_comb begin
    rd_value = 8'h00;
    case (shift_in[dpm_pkg::ADDR_W-1:0])
      dpm_pkg::REG_CONFIG: rd_value = cfg;
      dpm_pkg::REG_STATUS: begin
        rd_value[dpm_pkg::STS_SPI_BIT] = spi_mode;
        rd_value[dpm_pkg::STS_PD_BIT]  = eff_pd;
      end
      default: rd_value = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst || !cs_active) begin
      state    <= dpm_pkg::D_IDLE;               // see R5
      bit_cnt  <= 3'h0;
      shreg    <= 8'h00;
      instr    <= 8'h00;
      rd_drive <= 1'b0;
    end else begin
      case (state)
        dpm_pkg::D_IDLE: begin
          // select just fell; first serial rise is a half period away
          state <= dpm_pkg::D_INSTR;
        end
        dpm_pkg::D_INSTR: begin
          if (sclk_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            shreg   <= shift_in;
            if (bit_cnt == dpm_pkg::BIT_LAST) begin
              instr <= shift_in;
              state <= dpm_pkg::D_DATA;
              if (shift_in[dpm_pkg::INSTR_RD_BIT]) begin
                shreg <= rd_value;
              end
            end
          end
        end
        dpm_pkg::D_DATA: begin
          if (is_read) begin
            // wait for the host's falling edge so both ends never drive together
            if (sclk_fall) begin
              if (rd_drive) begin
                shreg <= {shreg[6:0], 1'b0};     // see R9
              end else begin
                rd_drive <= 1'b1;
              end
            end
          end else if (sclk_rise) begin
            shreg <= shift_in;
          end
          if (sclk_rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == dpm_pkg::BIT_LAST) begin
              state    <= dpm_pkg::D_DONE;
              rd_drive <= 1'b0;
            end
          end
        end
        dpm_pkg::D_DONE: begin
          // extra clocks are ignored until chip select rises
          state <= dpm_pkg::D_DONE;
        end
        default: begin
          state <= dpm_pkg::D_IDLE;
        end
      endcase
    end
  end

  assign wr_pulse = in_data & ~is_read & sclk_rise & (bit_cnt == dpm_pkg::BIT_LAST);

  // let go at the last rise, long before the host's next frame can start
  assign pins.sdio_dev_oe = in_data & is_read & rd_drive;   // see R9
  assign pins.sdio_dev_o  = shreg[7];

  ////////////////////////////////////////////////////////////////////////////
  // serial configuration register
  always_ff @(posedge i_clk) begin
    // level-sensitive clear, so a pulse of any width restores defaults
    if (i_srst || pins.mode_sel) begin
      cfg <= dpm_pkg::CFG_RESET;                  // see R3
    end else if (wr_pulse && (instr[dpm_pkg::ADDR_W-1:0] == dpm_pkg::REG_CONFIG)) begin
      cfg <= shift_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // effective settings: straps in pin mode, register in serial mode
  assign eff_twos = spi_mode ? cfg[dpm_pkg::CFG_TWOS_BIT]  : pins.sdio;            // see R6
  assign eff_diff = spi_mode ? cfg[dpm_pkg::CFG_DIFF_BIT]  : pins.clk_strap_sclk;  // see R7
  assign eff_pd   = spi_mode ? cfg[dpm_pkg::CFG_SLEEP_BIT] : pins.pd_cs;           // see R4

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_powerdown  <= 1'b0;
      o_twos_comp  <= 1'b0;
      o_diff_clock <= 1'b0;
    end else begin
      o_powerdown  <= eff_pd;                     // see R4
      o_twos_comp  <= eff_twos;                   // see R6
      o_diff_clock <= eff_diff;                   // see R7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode flag, kept apart from the strap settings
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_spi_mode <= 1'b0;
    end else begin
      o_spi_mode <= spi_mode;                     // see R2
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample path; the msb flip costs no extra latency
  logic [9:0]             next_code;

  assign next_code = dpm_pkg::dpm_core_code(pins.sample, eff_twos);   // see R11

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_core_code        <= dpm_pkg::CODE_RESET;
      o_primary_level    <= dpm_pkg::CODE_RESET;
      o_complement_level <= dpm_pkg::COMP_RESET;
    end else begin
      o_core_code        <= next_code;   // see R1, R11, R12
      o_primary_level    <= next_code;   // see R10
      o_complement_level <= ~next_code;  // see R10
    end
  end

endmodule
`default_nettype wire

// [dpm_host_end.sv]
// data source and serial configuration host, ordered over apb
`timescale 1ns/10ps
`default_nettype none
module dpm_host_end (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  dpm_if.host              pins
);

  logic [3:0]              ctrl;
  logic [9:0]              sample;
  logic [15:0]             frame;
  logic [7:0]              rdata;
  logic                    busy;
  logic                    wr_acc;
  logic                    mapped;
  logic                    start;
  dpm_pkg::dpm_host_state_t state;
  logic [3:0]              half_cnt;
  logic [3:0]              bit_idx;
  logic                    cs_n;
  logic                    sclk;
  logic                    sdo;
  logic                    sdo_oe;
  logic                    pin_mode;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  assign mapped    = (i_paddr == dpm_pkg::APB_CTRL) | (i_paddr == dpm_pkg::APB_SAMPLE) |
                     (i_paddr == dpm_pkg::APB_SPI_CMD) | (i_paddr == dpm_pkg::APB_SPI_STAT);
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped;
  assign wr_acc    = i_psel & i_penable & i_pwrite & mapped;
  assign pin_mode  = ctrl[dpm_pkg::CTL_PIN_BIT];
  // commands while busy or in pin mode are dropped
  assign start     = wr_acc & (i_paddr == dpm_pkg::APB_SPI_CMD) & ~busy & ~pin_mode;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ctrl   <= dpm_pkg::CTRL_RESET;
      sample <= 10'h000;
    end else if (wr_acc) begin
      if (i_paddr == dpm_pkg::APB_CTRL) begin
        ctrl <= i_pwdata[3:0];                   // see R2, R3
      end
      if (i_paddr == dpm_pkg::APB_SAMPLE) begin
        sample <= i_pwdata[9:0];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && !i_penable) begin
      case (i_paddr)
        dpm_pkg::APB_CTRL:     o_prdata <= {28'h000_0000, ctrl};
        dpm_pkg::APB_SAMPLE:   o_prdata <= {22'h00_0000, sample};
        dpm_pkg::APB_SPI_CMD:  o_prdata <= {16'h0000, frame};
        dpm_pkg::APB_SPI_STAT: o_prdata <= {23'h00_0000, busy, rdata};
        default:               o_prdata <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial master: data changes with sclk low, sampled at sclk rise
  always_ff @(posedge i_clk) begin
    if (i_srst || pin_mode) begin
      state    <= dpm_pkg::H_IDLE;
      busy     <= 1'b0;
      half_cnt <= 4'h0;
      bit_idx  <= 4'h0;
      cs_n     <= 1'b1;
      sclk     <= 1'b0;
      sdo      <= 1'b0;
      sdo_oe   <= 1'b0;
      frame    <= 16'h0000;
      rdata    <= 8'h00;
    end else begin
      case (state)
        dpm_pkg::H_IDLE: begin
          if (start) begin
            frame    <= i_pwdata[15:0];
            busy     <= 1'b1;
            cs_n     <= 1'b0;                    // see R5
            sdo      <= i_pwdata[15];
            sdo_oe   <= 1'b1;
            bit_idx  <= 4'h0;
            half_cnt <= 4'h0;
            state    <= dpm_pkg::H_LOW;
          end
        end
        dpm_pkg::H_LOW: begin
          half_cnt <= half_cnt + 4'h1;
          if (half_cnt == dpm_pkg::HALF_LAST) begin
            half_cnt <= 4'h0;
            sclk     <= 1'b1;                    // see R8
            state    <= dpm_pkg::H_HIGH;
            if (frame[dpm_pkg::CMD_RD_BIT] && bit_idx >= dpm_pkg::DATA_FIRST) begin
              rdata <= {rdata[6:0], pins.sdio};  // see R9
            end
          end
        end
        dpm_pkg::H_HIGH: begin
          half_cnt <= half_cnt + 4'h1;
          if (half_cnt == dpm_pkg::HALF_LAST) begin
            half_cnt <= 4'h0;
            sclk     <= 1'b0;
            if (bit_idx == dpm_pkg::FRAME_LAST) begin
              sdo_oe <= 1'b0;
              state  <= dpm_pkg::H_END;
            end else begin
              bit_idx <= bit_idx + 4'h1;
              sdo     <= frame[4'hE - bit_idx];
              // release the line for the read data phase
              sdo_oe  <= ~(frame[dpm_pkg::CMD_RD_BIT] && (bit_idx + 4'h1) >= dpm_pkg::DATA_FIRST);  // see R9
              state   <= dpm_pkg::H_LOW;
            end
          end
        end
        dpm_pkg::H_END: begin
          half_cnt <= half_cnt + 4'h1;
          if (half_cnt == dpm_pkg::HALF_LAST) begin
            cs_n  <= 1'b1;
            busy  <= 1'b0;
            state <= dpm_pkg::H_IDLE;
          end
        end
        default: begin
          state <= dpm_pkg::H_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin sharing between strap and serial roles
  assign pins.sample         = sample;                                                // see R1
  assign pins.mode_sel       = pin_mode;                                              // see R2
  assign pins.pd_cs          = pin_mode ? ctrl[dpm_pkg::CTL_SLEEP_BIT] : cs_n;        // see R4, R5
  assign pins.clk_strap_sclk = pin_mode ? ctrl[dpm_pkg::CTL_DIFF_BIT] : sclk;         // see R7, R8
  assign pins.sdio_host_o    = pin_mode ? ctrl[dpm_pkg::CTL_TWOS_BIT] : sdo;          // see R6, R9
  assign pins.sdio_host_oe   = pin_mode | sdo_oe;

endmodule
`default_nettype wire

// [dpm_checker.sv]
// concurrent checks on the link between the host end and the converter control end
`timescale 1ns/10ps
`default_nettype none
module dpm_checker (
  input wire logic       i_clk,
  input wire logic       i_srst,
  input wire logic [9:0] sample,
  input wire logic       mode_sel,
  input wire logic       pd_cs,
  input wire logic       clk_strap_sclk,
  input wire logic       sdio_host_oe,
  input wire logic       sdio_dev_oe,
  input wire logic       sdio,
  input wire logic [9:0] o_core_code,
  input wire logic [9:0] o_primary_level,
  input wire logic [9:0] o_complement_level,
  input wire logic       o_powerdown,
  input wire logic       o_twos_comp,
  input wire logic       o_diff_clock,
  input wire logic       o_spi_mode
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  ////////////////////////////////////////////////////////
  // strap decode and sample path
  // strap held two cycles so either twos register timing passes
  AST_CORE_CAPTURE: assert property (
    (!$past(i_srst) && !$past(i_srst, 2) && $past(mode_sel) && $past(mode_sel, 2) && $past(sdio) == $past(sdio, 2))
    |-> o_core_code == {$past(sample[9]) ^ $past(sdio), $past(sample[8:0])})
    else $error("core code does not follow captured sample");
  AST_LEVELS: assert property (
    o_primary_level == o_core_code && o_complement_level == ~o_core_code)
    else $error("output levels disagree with core code");
  AST_PIN_POWERDOWN: assert property (
    (!$past(i_srst) && $past(mode_sel)) |-> o_powerdown == $past(pd_cs))
    else $error("pin mode powerdown wrong");
  AST_SPI_MODE: assert property (
    !$past(i_srst) |-> o_spi_mode == !$past(mode_sel))
    else $error("mode decode wrong");
  AST_PIN_DIFF: assert property (
    (!$past(i_srst) && $past(mode_sel)) |-> o_diff_clock == $past(clk_strap_sclk))
    else $error("clock receiver strap wrong");
  AST_MODE_RESET: assert property (
    $fell(mode_sel) |=> (o_spi_mode && !o_twos_comp && !o_diff_clock && !o_powerdown) [*3])
    else $error("serial settings not at default after mode pulse");

  ////////////////////////////////////////////////////////
  // serial wire
  AST_DEV_OE_FRAMED: assert property (
    $rose(sdio_dev_oe) |-> !mode_sel && !pd_cs && !clk_strap_sclk)
    else $error("device drives data line outside a frame");
  AST_NO_CONTENTION: assert property (
    !(sdio_dev_oe && sdio_host_oe))
    else $error("both ends drive the data line");
  AST_SCLK_HALF: assert property (
    ($rose(clk_strap_sclk) && !mode_sel) |-> !pd_cs && !$past(clk_strap_sclk, 4) && !$past(clk_strap_sclk, 2))
    else $error("serial clock rise outside frame or short low half");
endmodule
`default_nettype wire

// [dac_pin_mode_config_tb.sv]
// self-checking bench for both ends of the converter control link
`timescale 1ns/10ps
`default_nettype none
module dac_pin_mode_config_tb;
  logic        i_clk   = 1'b0;
  logic        i_srst  = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [9:0]  core, prim, comp;
  logic        pd, twos, diff, spi;
  logic [31:0] rd;
  logic        err;
  logic [15:0] cap = 16'h0000;
  int          rises = 0;
  int          n_fail = 0;
  int          cmp_count = 0;

  dpm_if ifc ();
  always #25 i_clk = ~i_clk;

  dpm_host_end u_dpm_host_end (.i_clk(i_clk), .i_srst(i_srst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .pins(ifc.host));
  dpm_dev_end u_dpm_dev_end (.i_clk(i_clk), .i_srst(i_srst), .pins(ifc.dev), .o_core_code(core),
    .o_primary_level(prim), .o_complement_level(comp), .o_powerdown(pd), .o_twos_comp(twos),
    .o_diff_clock(diff), .o_spi_mode(spi));
  dpm_checker u_dpm_checker (.i_clk(i_clk), .i_srst(i_srst), .sample(ifc.sample), .mode_sel(ifc.mode_sel),
    .pd_cs(ifc.pd_cs), .clk_strap_sclk(ifc.clk_strap_sclk), .sdio_host_oe(ifc.sdio_host_oe),
    .sdio_dev_oe(ifc.sdio_dev_oe), .sdio(ifc.sdio), .o_core_code(core), .o_primary_level(prim),
    .o_complement_level(comp), .o_powerdown(pd), .o_twos_comp(twos), .o_diff_clock(diff), .o_spi_mode(spi));

  // wire monitor: serial bits as the device sees them, msb first
  always @(posedge ifc.clk_strap_sclk) begin
    if (!ifc.mode_sel && !ifc.pd_cs) begin
      rises = rises + 1;
      cap = {cap[14:0], ifc.sdio};
    end
  end

  ////////////////////////////////////////////////////////
  // shared tasks
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; no wait count assumed, bounded by a timeout
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      report_and_stop();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle();
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
  endtask

  ////////////////////////////////////////////////////////
  // scenarios
  task automatic put_sample(input logic [9:0] s, input logic t);
    logic [9:0] e;
    e = {s[9] ^ t, s[8:0]};
    apb(1'b1, dpm_pkg::APB_SAMPLE, {22'h0, s}, rd, err);
    settle();
    chk(ifc.sample, s);
    chk(core, e);
    chk(prim, e);
    chk(comp, 10'(~e));
  endtask

  task automatic spi_frame(input logic r, input logic [4:0] a, input logic [7:0] d, input logic [7:0] e);
    int n;
    rises = 0;
    apb(1'b1, dpm_pkg::APB_SPI_CMD, {16'h0, r, 2'b00, a, d}, rd, err);
    repeat (2) @(posedge i_clk);
    n = 0;
    do begin
      apb(1'b0, dpm_pkg::APB_SPI_STAT, 32'h0, rd, err);
      n++;
    end while (rd[8] !== 1'b0 && n < 200);
    if (n >= 200) begin
      n_fail++;
      report_and_stop();
    end
    chk(rises, 16);
    chk(cap, {r, 2'b00, a, (r ? e : d)});
    if (r) begin
      chk(rd[7:0], e);
    end
  endtask

  task automatic reset_state();
    chk(comp, 10'h3FF);
    chk(ifc.mode_sel, 1'b1);
  endtask

  task automatic pin_straps();
    put_sample(10'h3FF, 1'b0);
    put_sample(10'h000, 1'b0);
    put_sample(10'h200, 1'b0);
    chk(spi, 1'b0);
    apb(1'b1, dpm_pkg::APB_CTRL, 32'h5, rd, err);
    settle();
    chk(ifc.sdio, 1'b1);
    chk(twos, 1'b1);
    put_sample(10'h200, 1'b1);
    put_sample(10'h1FF, 1'b1);
    apb(1'b1, dpm_pkg::APB_CTRL, 32'h3, rd, err);
    settle();
    chk(pd, 1'b1);
    apb(1'b1, dpm_pkg::APB_CTRL, 32'h9, rd, err);
    settle();
    chk(diff, 1'b1);
    chk(pd, 1'b0);
  endtask

  // unmapped place is refused and reads zero
  task automatic unmapped_read();
    apb(1'b0, 12'h010, 32'h0, rd, err);
    chk(err, 1'b1);
    chk(rd, 32'h0);
  endtask

  task automatic serial_config();
    apb(1'b1, dpm_pkg::APB_CTRL, 32'h0, rd, err);
    settle();
    chk(spi, 1'b1);
    chk(diff, 1'b0);
    spi_frame(1'b0, dpm_pkg::REG_CONFIG, 8'h02, 8'h00);
    settle();
    chk(twos, 1'b1);
    put_sample(10'h3FF, 1'b1);
    spi_frame(1'b1, dpm_pkg::REG_CONFIG, 8'h00, 8'h02);
    spi_frame(1'b1, dpm_pkg::REG_STATUS, 8'h00, 8'h01);
    spi_frame(1'b1, 5'h1F, 8'h00, 8'h00);
    // sleep and receiver type come from the register in serial mode
    spi_frame(1'b0, dpm_pkg::REG_CONFIG, 8'h05, 8'h00);
    settle();
    chk(pd, 1'b1);
    chk(diff, 1'b1);
    chk(twos, 1'b0);
    spi_frame(1'b1, dpm_pkg::REG_STATUS, 8'h00, 8'h03);
  endtask

  // short pin-mode pulse must restore serial defaults
  task automatic mode_pulse();
    apb(1'b1, dpm_pkg::APB_CTRL, 32'h1, rd, err);
    apb(1'b1, dpm_pkg::APB_CTRL, 32'h0, rd, err);
    settle();
    chk(twos, 1'b0);
    chk(pd, 1'b0);
    chk(diff, 1'b0);
    spi_frame(1'b1, dpm_pkg::REG_CONFIG, 8'h00, 8'h00);
  endtask

  initial begin
    repeat (16) @(posedge i_clk);
    i_srst <= 1'b0;
    @(negedge i_clk);
    reset_state();
    pin_straps();
    unmapped_read();
    serial_config();
    mode_pulse();
    report_and_stop();
  end
endmodule
`default_nettype wire
